// [logic/bps_bank.sv]
`timescale 1ns/100ps
// How it works
// - Read-only 16-bit application status word, meaningful in direct-control mode.
// - Speed reference is unsigned 16 bits, legal range zero to 10000.
// - Reference zero means minimum frequency limit, 10000 means maximum.
// - One count of reference and feedback is 0.01 percent of span.
// - Direction for the reference comes from control word bit 1.
// - Speed feedback is read-only, zero to 10000, same frequency mapping.
// - Actual direction is reported in status word bit 2.
// - Speed reference is read/write and steers motor only in direct mode.
// - Each item mapping object, 0x1601 to 0x1604, carries exactly four items.
// - Eight items always; items nine to sixteen only with extended exchange.
// - Without extended exchange, items nine to sixteen are discarded.
// - Sixteen items writable in both modes, reachable as sub-entries 1-16.
// - Each item takes two datagram bytes, low byte first.
module bps_bank
(
  input wire logic clk,
  input wire logic arst_n,
  input wire bps_pkg::bps_od_req_t od_req,
  output bps_pkg::bps_od_rsp_t od_rsp,
  input wire logic pd_valid,
  output logic pd_ready,
  input wire bps_pkg::bps_byte_t pd_byte,
  input wire bps_pkg::bps_drive_in_t drive_in,
  output bps_pkg::bps_drive_out_t drive_out
);
  import bps_pkg::*;

  typedef struct packed
  {
    bps_parse_t parse;
    logic [BUF_DEPTH-1:0][8:0] buf_mem;
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_cnt;
    logic [7:0] low_byte;
    logic [3:0] pdo_ptr;
    logic [1:0] word_ptr;
    bps_od_rsp_t rsp;
    logic [15:0] speed_ref;
    logic [15:0] speed_cmd;
    logic [15:0] fixed_ctrl;
    logic [15:0] general_ctrl;
    logic [ITEM_COUNT-1:0][15:0] items;
    logic [3:0] asg_cnt;
    logic [ASSIGN_DEPTH-1:0][15:0] asg;
  } bps_state_t;

  bps_state_t s_q;
  bps_state_t s_d;

  // Saturating clamp shared by reference writes and feedback reads
  function automatic logic [15:0] clamp_speed(input logic [15:0] v);
    clamp_speed = (v > SPEED_MAX) ? SPEED_MAX : v;
  endfunction : clamp_speed

  function automatic logic is_item_pdo(input logic [15:0] idx);
    is_item_pdo = (idx >= PDO_ITEMS_FIRST) && (idx <= PDO_ITEMS_LAST);
  endfunction : is_item_pdo

  // Number of 16-bit words that one assigned mapping object carries
  function automatic logic [1:0] pdo_words(input logic [15:0] idx);
    if (is_item_pdo(idx))
    begin
      pdo_words = 2'(ITEMS_PER_PDO);
    end
    else if (idx == PDO_DIRECT)
    begin
      pdo_words = WORDS_DIRECT;
    end
    else
    begin
      pdo_words = WORDS_PROFILE;
    end
  endfunction : pdo_words

  // Dictionary entry that a word of a mapping object lands in
  function automatic logic [23:0] pdo_target(input logic [15:0] idx,
                                             input logic [1:0] wp);
    logic [15:0] rel;
    rel = idx - PDO_ITEMS_FIRST;
    if (is_item_pdo(idx))
    begin
      pdo_target = {OD_ITEMS, rel[5:0], wp} + 24'h00_0001;
    end
    else if (idx == PDO_DIRECT)
    begin
      case (wp)
        2'h0: pdo_target = {OD_CTRL, SUB_FIXED};
        2'h1: pdo_target = {OD_CTRL, SUB_GENERAL};
        default: pdo_target = {OD_SPEED_REF, SUB_VALUE};
      endcase
    end
    else
    begin
      // Profile words are consumed and dropped; they map to no entry here
      pdo_target = 24'h00_0000;
    end
  endfunction : pdo_target

  // Whether a write to an entry is accepted
  function automatic logic od_write_ok(input bps_state_t s,
                                       input logic [15:0] idx,
                                       input logic [7:0] sub,
                                       input logic [15:0] data);
    od_write_ok = 1'b0;
    case (idx)
      OD_CTRL: od_write_ok = (sub == SUB_FIXED) || (sub == SUB_GENERAL);
      OD_SPEED_REF: od_write_ok = (sub == SUB_VALUE);
      OD_ITEMS: od_write_ok = (sub >= 8'h01) && (sub <= 8'(ITEM_COUNT));
      OD_RX_ASSIGN:
      begin
        if (sub == SUB_COUNT)
        begin
          od_write_ok = (data <= 16'(ASSIGN_DEPTH));
        end
        else
        begin
          // Entries only change while the count is held at zero
          od_write_ok = (s.asg_cnt == ASSIGN_COUNT_RESET) &&
                        (sub <= 8'(ASSIGN_DEPTH)) &&
                        (is_item_pdo(data) || data == PDO_DIRECT ||
                         data == PDO_PROFILE);
        end
      end
      default: od_write_ok = 1'b0;
    endcase
  endfunction : od_write_ok

  // Store one accepted write; shared by the dictionary port and the stream
  function automatic bps_state_t od_write(input bps_state_t s,
                                          input logic [15:0] idx,
                                          input logic [7:0] sub,
                                          input logic [15:0] data);
    bps_state_t n;
    logic [7:0] slot;
    n = s;
    slot = sub - 8'h01;
    if (od_write_ok(s, idx, sub, data))
    begin
      case (idx)
        OD_CTRL:
        begin
          if (sub == SUB_FIXED)
          begin
            n.fixed_ctrl = data;
          end
          else
          begin
            n.general_ctrl = data;
          end
        end
        OD_SPEED_REF: n.speed_ref = clamp_speed(data);
        OD_ITEMS: n.items[slot[3:0]] = data;
        OD_RX_ASSIGN:
        begin
          if (sub == SUB_COUNT)
          begin
            n.asg_cnt = data[3:0];
          end
          else
          begin
            n.asg[slot[2:0]] = data;
          end
        end
        default: n = s;
      endcase
    end
    od_write = n;
  endfunction : od_write

  // Read side of the dictionary
  function automatic logic [16:0] od_read(input bps_state_t s,
                                          input bps_drive_in_t din,
                                          input logic [15:0] idx,
                                          input logic [7:0] sub);
    logic [15:0] st;
    logic [7:0] slot;
    st = din.fixed_status;
    st[STATUS_DIR_BIT] = din.dir_feedback;
    slot = sub - 8'h01;
    od_read = {1'b0, WORD_RESET};
    case (idx)
      OD_CTRL:
      begin
        if (sub == SUB_FIXED)
        begin
          od_read = {1'b1, s.fixed_ctrl};
        end
        else if (sub == SUB_GENERAL)
        begin
          od_read = {1'b1, s.general_ctrl};
        end
      end
      OD_STATUS:
      begin
        if (sub == SUB_FIXED)
        begin
          od_read = {1'b1, st};
        end
        else if (sub == SUB_GENERAL)
        begin
          od_read = {1'b1, din.app_status};
        end
      end
      OD_SPEED_REF:
      begin
        if (sub == SUB_VALUE)
        begin
          od_read = {1'b1, s.speed_ref};
        end
      end
      OD_SPEED_FB:
      begin
        if (sub == SUB_VALUE)
        begin
          od_read = {1'b1, clamp_speed(din.speed_feedback)};
        end
      end
      OD_ITEMS:
      begin
        if (sub >= 8'h01 && sub <= 8'(ITEM_COUNT))
        begin
          od_read = {1'b1, s.items[slot[3:0]]};
        end
      end
      OD_RX_ASSIGN:
      begin
        if (sub == SUB_COUNT)
        begin
          od_read = {1'b1, 12'h000, s.asg_cnt};
        end
        else if (sub <= 8'(ASSIGN_DEPTH))
        begin
          od_read = {1'b1, s.asg[slot[2:0]]};
        end
      end
      default: od_read = {1'b0, WORD_RESET};
    endcase
  endfunction : od_read

  logic buf_push;
  logic buf_pop;
  bps_byte_t head;

  // A dictionary access owns the storage for its cycle, so the
  // stream waits rather than racing it for the same entry
  assign pd_ready = (s_q.buf_cnt != 2'(BUF_DEPTH));
  assign buf_push = pd_valid && pd_ready;
  assign buf_pop = (s_q.buf_cnt != 2'h0) && !od_req.valid;
  assign head = s_q.buf_mem[s_q.buf_rp];

  // Next-state logic for the whole bank
  always_comb
  begin
    logic [16:0] rd;
    logic [15:0] word;
    logic [15:0] cur_pdo;
    logic [23:0] tgt;
    s_d = s_q;
    rd = 17'h0_0000;
    word = WORD_RESET;
    cur_pdo = s_q.asg[s_q.pdo_ptr[2:0]];
    tgt = pdo_target(cur_pdo, s_q.word_ptr);

    // Two-entry buffer between the datagram and the parser
    if (buf_push)
    begin
      s_d.buf_mem[s_q.buf_wp] = pd_byte;
      s_d.buf_wp = ~s_q.buf_wp;
    end
    if (buf_pop)
    begin
      s_d.buf_rp = ~s_q.buf_rp;
    end
    s_d.buf_cnt = s_q.buf_cnt + 2'(buf_push) - 2'(buf_pop);

    // Dictionary port: answer one cycle after the request
    s_d.rsp.valid = od_req.valid;
    s_d.rsp.ok = 1'b0;
    s_d.rsp.rdata = WORD_RESET;
    if (od_req.valid && od_req.write)
    begin
      s_d.rsp.ok = od_write_ok(s_q, od_req.index, od_req.sub,
                               od_req.wdata);
      s_d = od_write(s_d, od_req.index, od_req.sub, od_req.wdata);
    end
    else if (od_req.valid)
    begin
      rd = od_read(s_q, drive_in, od_req.index, od_req.sub);
      s_d.rsp.ok = rd[16];
      s_d.rsp.rdata = rd[15:0];
    end

    // Byte parser: a frame opens with a low byte
    if (buf_pop)
    begin
      if (head.sof)
      begin
        s_d.low_byte = head.data;
        s_d.pdo_ptr = 4'h0;
        s_d.word_ptr = 2'h0;
        s_d.parse = PS_HIGH;
      end
      else
      begin
        case (s_q.parse)
          PS_LOW:
          begin
            s_d.low_byte = head.data;
            s_d.parse = PS_HIGH;
          end
          PS_HIGH:
          begin
            word = {head.data, s_q.low_byte};
            s_d.parse = PS_LOW;
            // Bytes past the last assigned object are dropped
            if (s_q.pdo_ptr < s_q.asg_cnt)
            begin
              s_d = od_write(s_d, tgt[23:8], tgt[7:0], word);
              if (s_q.word_ptr == pdo_words(cur_pdo) - 2'h1)
              begin
                s_d.word_ptr = 2'h0;
                s_d.pdo_ptr = s_q.pdo_ptr + 4'h1;
              end
              else
              begin
                s_d.word_ptr = s_q.word_ptr + 2'h1;
              end
            end
          end
          default: s_d.parse = PS_IDLE;
        endcase
      end
    end

    // Upper items are thrown away unless the drive takes all sixteen
    for (int i = ITEM_BASE_COUNT; i < ITEM_COUNT; i++)
    begin
      if (!drive_in.ext_items)
      begin
        s_d.items[i] = WORD_RESET;
      end
    end

    // The reference reaches the motor only in direct-control mode;
    // the limits scale it downstream, one count per 0.01 percent
    s_d.speed_cmd = drive_in.direct_mode ? s_d.speed_ref
                                         : WORD_RESET;
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.parse <= PS_IDLE;
      s_q.asg_cnt <= ASSIGN_COUNT_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign od_rsp = s_q.rsp;
  assign drive_out.speed_cmd = s_q.speed_cmd;
  assign drive_out.dir_reverse = s_q.fixed_ctrl[CTRL_DIR_BIT];
  assign drive_out.fixed_ctrl = s_q.fixed_ctrl;
  assign drive_out.general_ctrl = s_q.general_ctrl;
  assign drive_out.items = s_q.items;

endmodule : bps_bank

// [logic/bps_pkg.sv]
package bps_pkg;

  // Object dictionary indices and sub-indices
  localparam logic [15:0] OD_CTRL = 16'h5FFA;
  localparam logic [15:0] OD_STATUS = 16'h5FFB;
  localparam logic [15:0] OD_SPEED_REF = 16'h5FFC;
  localparam logic [15:0] OD_SPEED_FB = 16'h5FFD;
  localparam logic [15:0] OD_ITEMS = 16'h5FFE;
  localparam logic [15:0] OD_RX_ASSIGN = 16'h1C12;
  localparam logic [7:0] SUB_FIXED = 8'h01;
  localparam logic [7:0] SUB_GENERAL = 8'h02;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_VALUE = 8'h00;

  // Receive mapping objects that may be assigned
  localparam logic [15:0] PDO_PROFILE = 16'h1600;
  localparam logic [15:0] PDO_ITEMS_FIRST = 16'h1601;
  localparam logic [15:0] PDO_ITEMS_LAST = 16'h1604;
  localparam logic [15:0] PDO_DIRECT = 16'h1610;
  localparam logic [1:0] WORDS_PROFILE = 2'h2;
  localparam logic [1:0] WORDS_DIRECT = 2'h3;
  localparam logic [2:0] ITEMS_PER_PDO = 3'h4;

  // Field positions and sizes
  localparam int CTRL_DIR_BIT = 1;
  localparam int STATUS_DIR_BIT = 2;
  localparam int ITEM_COUNT = 16;
  localparam int ITEM_BASE_COUNT = 8;
  localparam int ASSIGN_DEPTH = 8;
  localparam int BUF_DEPTH = 2;

  // Value limits and reset values
  localparam logic [15:0] SPEED_MAX = 16'h2710;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0] ASSIGN_COUNT_RESET = 4'h0;

  typedef enum logic [2:0]
  {
    PS_IDLE = 3'b001,
    PS_LOW = 3'b010,
    PS_HIGH = 3'b100
  } bps_parse_t;

  // Object dictionary access, request and answer
  typedef struct packed
  {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] wdata;
  } bps_od_req_t;

  typedef struct packed
  {
    logic valid;
    logic ok;
    logic [15:0] rdata;
  } bps_od_rsp_t;

  // One datagram byte; sof marks the first byte of a frame
  typedef struct packed
  {
    logic sof;
    logic [7:0] data;
  } bps_byte_t;

  // Values coming from the drive application
  typedef struct packed
  {
    logic direct_mode;
    logic ext_items;
    logic [15:0] fixed_status;
    logic dir_feedback;
    logic [15:0] app_status;
    logic [15:0] speed_feedback;
  } bps_drive_in_t;

  // Commands going to the drive application
  typedef struct packed
  {
    logic [15:0] speed_cmd;
    logic dir_reverse;
    logic [15:0] fixed_ctrl;
    logic [15:0] general_ctrl;
    logic [ITEM_COUNT-1:0][15:0] items;
  } bps_drive_out_t;

endpackage : bps_pkg

// [test/bps_chk.sv]
`timescale 1ns/100ps
module bps_chk
(
  input wire logic clk,
  input wire logic arst_n,
  input wire bps_pkg::bps_od_req_t od_req,
  input wire bps_pkg::bps_od_rsp_t od_rsp,
  input wire logic pd_valid,
  input wire logic pd_ready,
  input wire bps_pkg::bps_byte_t pd_byte,
  input wire bps_pkg::bps_drive_in_t drive_in,
  input wire bps_pkg::bps_drive_out_t drive_out
);
  import bps_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Every access answered on the next edge, and only then
  AST_RSP_NEXT: assert property (od_req.valid |=> od_rsp.valid)
    else $error("access not answered");
  AST_RSP_NONE: assert property (!od_req.valid |=> !od_rsp.valid)
    else $error("answer without access");
  // Read-only status words refuse writes
  AST_RO_STATUS: assert property (od_req.valid && od_req.write
    && od_req.index == OD_STATUS |=> !od_rsp.ok)
    else $error("status write accepted");
  // Feedback is clamped, so a wild drive value never leaks out
  AST_FB_CLAMP: assert property (od_req.valid && !od_req.write
    && od_req.index == OD_SPEED_FB |=> od_rsp.ok && od_rsp.rdata ==
    ($past(drive_in.speed_feedback) > SPEED_MAX ? SPEED_MAX
    : $past(drive_in.speed_feedback)))
    else $error("feedback read wrong");
  AST_SPD_LIMIT: assert property (drive_out.speed_cmd <= SPEED_MAX)
    else $error("speed command above limit");
  AST_SPD_MODE: assert property (!drive_in.direct_mode ##1
    !drive_in.direct_mode |-> drive_out.speed_cmd == 16'h0000)
    else $error("speed command outside direct mode");
  AST_DIR_BIT: assert property (drive_out.dir_reverse ==
    drive_out.fixed_ctrl[CTRL_DIR_BIT])
    else $error("direction not from control bit");
  AST_EXT_OFF: assert property (!drive_in.ext_items ##1
    !drive_in.ext_items |-> drive_out.items[15:8] == '0)
    else $error("upper items kept without extension");
  // Buffer cannot drain while an access holds priority
  AST_FULL_HOLD: assert property (od_req.valid && !pd_ready |=> !pd_ready)
    else $error("full buffer freed during access");
  COV_FULL: cover property (pd_valid && !pd_ready);
  COV_REF: cover property (od_req.valid && od_req.index == OD_SPEED_REF);
  COV_B2B: cover property (od_req.valid [*2]);
endmodule : bps_chk

bind bps_bank bps_chk bps_chk_i (.clk(clk), .arst_n(arst_n), .od_req(od_req),
  .od_rsp(od_rsp), .pd_valid(pd_valid), .pd_ready(pd_ready),
  .pd_byte(pd_byte), .drive_in(drive_in), .drive_out(drive_out));

// [test/bps_master.sv]
`timescale 1ns/100ps
module bps_master
(
  input wire logic clk,
  input wire logic pd_ready,
  output logic pd_valid,
  output bps_pkg::bps_byte_t pd_byte
);
  import bps_pkg::*;
  // Idle line at start
  initial
  begin
    pd_valid = 1'b0;
    pd_byte = '{1'b0, 8'h5A};
  end
  // Offer one frame; each byte held until an edge sees room
  task send(input logic [15:0] w[$], input int gap);
    for (int i = 0; i < 2 * w.size(); i++)
    begin
      @(negedge clk);
      pd_valid = 1'b1;
      pd_byte = '{i == 0, w[i / 2][8 * (i % 2) +: 8]};
      // Room is judged at the falling edge, where ready has settled
      while (!pd_ready)
        @(negedge clk);
      @(posedge clk);
      if (gap > 0 || i == 2 * w.size() - 1)
      begin
        @(negedge clk);
        pd_valid = 1'b0;
        pd_byte.data = ~pd_byte.data; // Released line keeps no value
        repeat (gap) @(negedge clk);
      end
    end
  endtask : send
endmodule : bps_master

// [test/bps_bank_tb_top.sv]
`timescale 1ns/100ps
module bps_bank_tb_top;
  import bps_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  bps_od_req_t od_req = '0;
  bps_od_rsp_t od_rsp;
  bps_od_rsp_t rsp;
  logic pd_valid;
  logic pd_ready;
  bps_byte_t pd_byte;
  bps_drive_in_t drive_in = '0;
  bps_drive_out_t drive_out;
  int n_fail = 0;
  int n_compared = 0;
  logic [15:0] w[$];
  logic [15:0] refs[4] = '{16'h0000, 16'h2710, 16'h2711, 16'hFFFF};

  always #4 clk = ~clk;

  bps_bank bps_bank_i (.clk(clk), .arst_n(arst_n), .od_req(od_req),
    .od_rsp(od_rsp), .pd_valid(pd_valid), .pd_ready(pd_ready),
    .pd_byte(pd_byte), .drive_in(drive_in), .drive_out(drive_out));
  bps_master bps_master_i (.clk(clk), .pd_ready(pd_ready),
    .pd_valid(pd_valid), .pd_byte(pd_byte));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Valid stays up after a call so that accesses can run back to back
  task od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
    input logic [15:0] wd, input logic ok);
    od_req = '{1'b1, wr, idx, sub, wd};
    @(negedge clk);
    rsp = od_rsp;
    chk(16'({rsp.valid, rsp.ok}), 16'({1'b1, ok}));
  endtask : od
  task rd(input logic [15:0] idx, input logic [7:0] sub,
    input logic [15:0] exp, input logic ok);
    od(1'b0, idx, sub, 16'h0000, ok);
    chk(rsp.rdata, exp);
  endtask : rd
  task idle;
    od_req = '0;
    @(negedge clk);
  endtask : idle
  task print_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk(16'(pd_ready), 16'h0001);
    chk(drive_out.speed_cmd, 16'h0000);
    $display("reset test done");
    drive_in = '{1'b1, 1'b1, 16'h8001, 1'b1, 16'hA5C3, 16'h3000};
    rd(OD_STATUS, SUB_GENERAL, 16'hA5C3, 1'b1);
    od(1'b1, OD_STATUS, SUB_GENERAL, 16'h1234, 1'b0);
    rd(OD_STATUS, SUB_FIXED, 16'h8005, 1'b1);
    rd(OD_SPEED_FB, SUB_VALUE, SPEED_MAX, 1'b1);
    od(1'b1, OD_SPEED_FB, SUB_VALUE, 16'h0001, 1'b0);
    rd(16'h5FF0, SUB_VALUE, 16'h0000, 1'b0);
    od(1'b1, OD_SPEED_REF, SUB_VALUE, 16'h3000, 1'b1);
    rd(OD_SPEED_REF, SUB_VALUE, SPEED_MAX, 1'b1);
    od(1'b1, OD_CTRL, SUB_FIXED, 16'h0002, 1'b1);
    od(1'b1, OD_CTRL, SUB_GENERAL, 16'h5A5A, 1'b1);
    rd(OD_CTRL, SUB_GENERAL, 16'h5A5A, 1'b1);
    idle();
    chk(drive_out.speed_cmd, SPEED_MAX);
    chk(16'(drive_out.dir_reverse), 16'h0001);
    chk(drive_out.general_ctrl, 16'h5A5A);
    foreach (refs[i])
    begin
      od(1'b1, OD_SPEED_REF, SUB_VALUE, refs[i], 1'b1);
      rd(OD_SPEED_REF, SUB_VALUE,
        (refs[i] > SPEED_MAX) ? SPEED_MAX : refs[i], 1'b1);
    end
    drive_in.direct_mode = 1'b0;
    drive_in.speed_feedback = 16'h1388;
    rd(OD_SPEED_FB, SUB_VALUE, 16'h1388, 1'b1);
    idle();
    chk(drive_out.speed_cmd, 16'h0000);
    $display("register test done");
    for (int i = 1; i <= ITEM_COUNT; i++)
      od(1'b1, OD_ITEMS, 8'(i), 16'h1000 + 16'(i), 1'b1);
    for (int i = 1; i <= ITEM_COUNT; i++)
      rd(OD_ITEMS, 8'(i), 16'h1000 + 16'(i), 1'b1);
    drive_in.ext_items = 1'b0;
    repeat (2) idle();
    for (int i = 1; i <= ITEM_COUNT; i++)
      rd(OD_ITEMS, 8'(i), (i > ITEM_BASE_COUNT) ? 16'h0000
        : 16'h1000 + 16'(i), 1'b1);
    $display("item test done");
    drive_in.ext_items = 1'b1;
    drive_in.direct_mode = 1'b1;
    od(1'b1, OD_RX_ASSIGN, SUB_COUNT, 16'h0000, 1'b1);
    od(1'b1, OD_RX_ASSIGN, 8'h01, PDO_ITEMS_FIRST, 1'b1);
    od(1'b1, OD_RX_ASSIGN, 8'h02, PDO_ITEMS_LAST, 1'b1);
    od(1'b1, OD_RX_ASSIGN, 8'h03, PDO_DIRECT, 1'b1);
    od(1'b1, OD_RX_ASSIGN, 8'h04, 16'h1A00, 1'b0);
    od(1'b1, OD_RX_ASSIGN, SUB_COUNT, 16'h0009, 1'b0);
    od(1'b1, OD_RX_ASSIGN, SUB_COUNT, 16'h0003, 1'b1);
    od(1'b1, OD_RX_ASSIGN, 8'h01, PDO_PROFILE, 1'b0);
    idle();
    $display("assign test done");
    for (int i = 0; i < 8; i++)
      w.push_back(16'h03E9 + 16'(i));
    w.push_back(16'h0002);
    w.push_back(16'h0000);
    w.push_back(16'h1388);
    // Back-to-back accesses hold off the drain so the buffer fills up
    fork
      bps_master_i.send(w, 0);
      begin
        repeat (6) rd(OD_STATUS, SUB_GENERAL, 16'hA5C3, 1'b1);
        idle(); // Valid left up would hold off the drain for good
      end
    join
    idle();
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4; i++)
    begin
      chk(drive_out.items[i], 16'h03E9 + 16'(i));
      chk(drive_out.items[12 + i], 16'h03ED + 16'(i));
    end
    chk(drive_out.items[4], 16'h1005);
    chk(drive_out.fixed_ctrl, 16'h0002);
    chk(drive_out.speed_cmd, 16'h1388);
    chk(drive_out.general_ctrl, 16'h0000);
    w = '{16'h0BCD};
    bps_master_i.send(w, 1);
    repeat (4) @(negedge clk);
    chk(drive_out.items[0], 16'h0BCD);
    $display("stream test done");
    // Profile words are consumed and dropped; the next object follows
    od(1'b1, OD_RX_ASSIGN, SUB_COUNT, 16'h0000, 1'b1);
    od(1'b1, OD_RX_ASSIGN, 8'h01, PDO_PROFILE, 1'b1);
    od(1'b1, OD_RX_ASSIGN, 8'h02, 16'h1602, 1'b1);
    od(1'b1, OD_RX_ASSIGN, SUB_COUNT, 16'h0002, 1'b1);
    idle();
    w = '{16'h000F, 16'h012C, 16'h03ED, 16'h03EE, 16'h03EF, 16'h03F0};
    bps_master_i.send(w, 0);
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4; i++)
      chk(drive_out.items[4 + i], 16'h03ED + 16'(i));
    chk(drive_out.items[0], 16'h0BCD);
    chk(drive_out.fixed_ctrl, 16'h0002);
    $display("profile test done");
    // Reset in mid-run clears the bank and the assignment
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk(16'(pd_ready), 16'h0001);
    chk(drive_out.items[4], 16'h0000);
    chk(drive_out.fixed_ctrl, 16'h0000);
    chk(drive_out.speed_cmd, 16'h0000);
    rd(OD_RX_ASSIGN, SUB_COUNT, 16'h0000, 1'b1);
    idle();
    $display("second reset test done");
    print_verdict();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    n_fail++;
    print_verdict();
  end
endmodule : bps_bank_tb_top
